//--- common/csf_pkg.sv
// Shared constants, types and register map of the codec frame-sync slave.
// Assumes a 32-bit classic Wishbone host and an external codec driving
// the bit clock and the frame sync.
//
// Functional notes
// - With the frame-sync direction set to input the block is a slave and the codec paces every transfer.
// - The frame-sync mode field picks multichannel, I2S-style or AC-Link handling of the sync input.
// - Multichannel: a frame starts one bit-clock cycle after the sync is sampled high.
// - Multichannel: a sampled sync pulse resets the frame generator counters.
// - I2S-style: a word starts one bit-clock cycle after a sampled edge of either sense on the sync.
// - I2S-style: a sampled sync edge when no frame is running resets the frame generator counters.
// - AC-Link: the tag slot and data slots start one bit-clock cycle after the sync is sampled high.
// - Frame length follows the programmed frame length and word size settings.
// - A valid sync yields one complete frame unless slave mode is left before the frame ends.
// - Sync events during a frame are ignored until the frame completes.
`default_nettype none

package csf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_00f2;
  localparam int CTRL_W = 12;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RXV_BIT = 1;
  localparam int ST_OVR_BIT = 2;
  localparam int ST_UNF_BIT = 3;
  localparam int ST_FULL_BIT = 4;
  localparam int ST_EMPTY_BIT = 5;

  // ****************************************
  // Data path
  // ****************************************
  localparam int WORD_W = 16;
  localparam logic [3:0] WORD_SIZE_MAX = 4'hf;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    FSM_MULTI = 2'h0,
    FSM_I2S = 2'h1,
    FSM_ACLINK = 2'h2
  } csf_mode_t;

  typedef struct packed {
    logic [3:0] frame_gen_length;
    logic [3:0] word_size;
    logic [1:0] fsync_mode;
    logic fsync_direction;
    logic enable;
  } csf_cfg_t;

  typedef struct packed {
    logic sck;
    logic fsync;
    logic sdi;
  } csf_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_XFER = 3'b100
  } csf_state_t;

endpackage : csf_pkg

`default_nettype wire

//--- rtl/csf_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output is a clean level on clk_in.
`default_nettype none

module csf_sync3 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);

  logic [2:0] stage;
  logic q;
  logic [2:0] next_stage;
  logic next_q;

  // ****************************************
  // Next state
  // ****************************************
  // First stage feeds only the second, to keep metastability contained
  always_comb begin
    next_stage = {stage[1:0], d_in};
    next_q = q;
    if (stage[1] == stage[2]) begin
      next_q = stage[2];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage <= 3'h0;
      q <= 1'b0;
    end else begin
      stage <= next_stage;
      q <= next_q;
    end
  end

  assign q_out = q;

endmodule : csf_sync3

`default_nettype wire

//--- rtl/csf_fifo2.sv
// Two-entry word buffer with valid/ready on both sides.
// Assumes both sides on clk_in.
`default_nettype none

module csf_fifo2 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [csf_pkg::WORD_W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [csf_pkg::WORD_W-1:0] out_data_out
);

  logic [csf_pkg::WORD_W-1:0] mem [0:1];
  logic wptr;
  logic rptr;
  logic [1:0] count;
  logic [csf_pkg::WORD_W-1:0] next_mem [0:1];
  logic next_wptr;
  logic next_rptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid_in & (count != 2'h2);
    pop = out_ready_in & (count != 2'h0);
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (push) begin
      next_mem[wptr] = in_data_in;
      next_wptr = ~wptr;
    end
    if (pop) begin
      next_rptr = ~rptr;
    end
    if (push & ~pop) begin
      next_count = count + 2'h1;
    end else if (pop & ~push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rptr];

endmodule : csf_fifo2

`default_nettype wire

//--- rtl/csf_slave.sv
// Frame-sync slave serial codec interface with Wishbone registers.
// Assumes a classic Wishbone master on clk_in and a codec that drives
// the bit clock and frame sync, both sampled here as async inputs.
`default_nettype none

module csf_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic serial_bit_clock_in,
  input wire logic frame_sync_pin_in,
  input wire logic serial_data_in,
  output logic serial_data_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  csf_pkg::csf_pins_t pins;

  csf_sync3 u_sync_sck (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(serial_bit_clock_in),
    .q_out(pins.sck)
  );

  csf_sync3 u_sync_fs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(frame_sync_pin_in),
    .q_out(pins.fsync)
  );

  csf_sync3 u_sync_sdi (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(serial_data_in),
    .q_out(pins.sdi)
  );

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] ctrl;
  csf_pkg::csf_cfg_t cfg;
  logic ack;
  logic [31:0] dat;
  logic rx_valid;
  logic rx_overrun;
  logic tx_underflow;
  logic [csf_pkg::WORD_W-1:0] rx_data;
  logic [31:0] next_ctrl;
  logic next_ack;
  logic [31:0] next_dat;
  logic next_rx_valid;
  logic next_rx_overrun;
  logic next_tx_underflow;
  logic [csf_pkg::WORD_W-1:0] next_rx_data;

  csf_pkg::csf_state_t state;
  csf_pkg::csf_state_t next_state;
  logic sck_prev;
  logic fs_prev;
  logic [3:0] bit_cnt;
  logic [3:0] word_cnt;
  logic [csf_pkg::WORD_W-1:0] tx_shift;
  logic [csf_pkg::WORD_W-1:0] rx_shift;
  logic sdo;
  logic rx_push;
  logic unf_evt;
  logic next_sck_prev;
  logic next_fs_prev;
  logic [3:0] next_bit_cnt;
  logic [3:0] next_word_cnt;
  logic [csf_pkg::WORD_W-1:0] next_tx_shift;
  logic [csf_pkg::WORD_W-1:0] next_rx_shift;
  logic next_sdo;
  logic next_rx_push;
  logic next_unf_evt;

  logic req;
  logic tx_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [csf_pkg::WORD_W-1:0] fifo_out_data;
  logic sck_rise;
  logic slave_on;
  logic fs_evt;
  logic step;
  logic last_bit;
  logic last_word;
  logic [csf_pkg::WORD_W-1:0] load_word;
  logic [csf_pkg::WORD_W-1:0] rx_base;
  logic [csf_pkg::WORD_W-1:0] rx_next_word;
  logic [3:0] align;

  assign cfg = csf_pkg::csf_cfg_t'(ctrl[csf_pkg::CTRL_W-1:0]);

  // ****************************************
  // Transmit buffer
  // ****************************************
  // A full buffer withholds the bus ack, so software stalls, not drops
  csf_fifo2 u_txbuf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(tx_wr),
    .in_ready_out(fifo_in_ready),
    .in_data_in(wb_dat_in[csf_pkg::WORD_W-1:0]),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // ****************************************
  // Register bus
  // ****************************************
  always_comb begin
    req = wb_cyc_in & wb_stb_in & ~ack;
    tx_wr = req & wb_we_in & (wb_adr_in == csf_pkg::ADDR_TXDATA) &
            (wb_sel_in[1:0] != 2'h0);
    next_ctrl = ctrl;
    next_ack = req & ~(tx_wr & ~fifo_in_ready);
    next_dat = 32'h0000_0000;
    next_rx_data = rx_data;
    next_rx_valid = rx_valid;
    next_rx_overrun = rx_overrun;
    next_tx_underflow = tx_underflow;
    if (next_ack & wb_we_in) begin
      if (wb_adr_in == csf_pkg::ADDR_CTRL) begin
        if (wb_sel_in[0]) begin
          next_ctrl[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          next_ctrl[11:8] = wb_dat_in[11:8];
        end
      end
      if ((wb_adr_in == csf_pkg::ADDR_STATUS) & wb_sel_in[0]) begin
        if (wb_dat_in[csf_pkg::ST_OVR_BIT]) begin
          next_rx_overrun = 1'b0;
        end
        if (wb_dat_in[csf_pkg::ST_UNF_BIT]) begin
          next_tx_underflow = 1'b0;
        end
      end
    end
    if (next_ack & ~wb_we_in) begin
      case (wb_adr_in)
        csf_pkg::ADDR_CTRL: begin
          next_dat = {20'h00000, ctrl[csf_pkg::CTRL_W-1:0]};
        end
        csf_pkg::ADDR_STATUS: begin
          next_dat[csf_pkg::ST_BUSY_BIT] = (state != csf_pkg::ST_IDLE);
          next_dat[csf_pkg::ST_RXV_BIT] = rx_valid;
          next_dat[csf_pkg::ST_OVR_BIT] = rx_overrun;
          next_dat[csf_pkg::ST_UNF_BIT] = tx_underflow;
          next_dat[csf_pkg::ST_FULL_BIT] = ~fifo_in_ready;
          next_dat[csf_pkg::ST_EMPTY_BIT] = ~fifo_out_valid;
        end
        csf_pkg::ADDR_RXDATA: begin
          next_dat = {16'h0000, rx_data};
          next_rx_valid = 1'b0;
        end
        default: begin
          next_dat = 32'h0000_0000;
        end
      endcase
    end
    // Hardware events win over a clear in the same cycle
    if (rx_push) begin
      next_rx_data = rx_shift;
      next_rx_valid = 1'b1;
      if (rx_valid) begin
        next_rx_overrun = 1'b1;
      end
    end
    if (unf_evt) begin
      next_tx_underflow = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= csf_pkg::CTRL_RST;
      ack <= 1'b0;
      dat <= 32'h0000_0000;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_overrun <= 1'b0;
      tx_underflow <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ack <= next_ack;
      dat <= next_dat;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_overrun <= next_rx_overrun;
      tx_underflow <= next_tx_underflow;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = dat;

  // ****************************************
  // Frame engine
  // ****************************************
  always_comb begin
    sck_rise = pins.sck & ~sck_prev;
    slave_on = cfg.enable & cfg.fsync_direction;
    case (cfg.fsync_mode)
      csf_pkg::FSM_I2S: begin
        fs_evt = pins.fsync ^ fs_prev;
      end
      csf_pkg::FSM_ACLINK: begin
        fs_evt = pins.fsync;
      end
      default: begin
        fs_evt = pins.fsync;
      end
    endcase
    step = sck_rise & ((state == csf_pkg::ST_ARMED) |
                       (state == csf_pkg::ST_XFER));
    last_bit = (bit_cnt == cfg.word_size);
    last_word = (word_cnt == cfg.frame_gen_length);
    fifo_pop = step & (bit_cnt == 4'h0);
    align = csf_pkg::WORD_SIZE_MAX - cfg.word_size;
    load_word = fifo_out_valid ? (fifo_out_data << align) : '0;
    rx_base = (bit_cnt == 4'h0) ? '0 : rx_shift;
    rx_next_word = {rx_base[csf_pkg::WORD_W-2:0], pins.sdi};
    next_sck_prev = pins.sck;
    next_fs_prev = fs_prev;
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_word_cnt = word_cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_sdo = sdo;
    next_rx_push = 1'b0;
    next_unf_evt = 1'b0;
    if (sck_rise) begin
      next_fs_prev = pins.fsync;
    end
    case (state)
      csf_pkg::ST_IDLE: begin
        if (sck_rise & slave_on & fs_evt) begin
          // Sync resets the generator; the frame begins next bit clock
          next_state = csf_pkg::ST_ARMED;
          next_bit_cnt = 4'h0;
          next_word_cnt = 4'h0;
        end
      end
      csf_pkg::ST_ARMED, csf_pkg::ST_XFER: begin
        if (~slave_on) begin
          // Leaving slave mode abandons the frame
          next_state = csf_pkg::ST_IDLE;
        end else if (step) begin
          next_state = csf_pkg::ST_XFER;
          next_rx_shift = rx_next_word;
          if (bit_cnt == 4'h0) begin
            next_sdo = load_word[csf_pkg::WORD_W-1];
            next_tx_shift = load_word << 1;
            next_unf_evt = ~fifo_out_valid;
          end else begin
            next_sdo = tx_shift[csf_pkg::WORD_W-1];
            next_tx_shift = tx_shift << 1;
          end
          if (last_bit) begin
            next_bit_cnt = 4'h0;
            next_rx_push = 1'b1;
            next_word_cnt = word_cnt + 4'h1;
            if (last_word) begin
              // Only the closing edge may accept the next sync
              next_word_cnt = 4'h0;
              next_state = fs_evt ? csf_pkg::ST_ARMED
                                  : csf_pkg::ST_IDLE;
            end
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        next_state = csf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= csf_pkg::ST_IDLE;
      sck_prev <= 1'b0;
      fs_prev <= 1'b0;
      bit_cnt <= 4'h0;
      word_cnt <= 4'h0;
      tx_shift <= '0;
      rx_shift <= '0;
      sdo <= 1'b0;
      rx_push <= 1'b0;
      unf_evt <= 1'b0;
    end else begin
      state <= next_state;
      sck_prev <= next_sck_prev;
      fs_prev <= next_fs_prev;
      bit_cnt <= next_bit_cnt;
      word_cnt <= next_word_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      sdo <= next_sdo;
      rx_push <= next_rx_push;
      unf_evt <= next_unf_evt;
    end
  end

  assign serial_data_out = sdo;

endmodule : csf_slave

`default_nettype wire

//--- testbench/csf_properties.sv
// Checker: bus and link relations at the slave's ports.
// Assumes it is bound into csf_slave and sees its ports only.
`default_nettype none

module csf_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic serial_bit_clock_in,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic rd;
  logic req;
  assign rd = wb_ack_out && !wb_we_in;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;

  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
    else $error("ack without request");
  ack_prompt_a: assert property (
    req && wb_adr_in != csf_pkg::ADDR_TXDATA |=> wb_ack_out)
    else $error("ack late");
  rdata_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (
    rd && wb_adr_in > 8'h0c |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  tx_read_zero_a: assert property (
    rd && wb_adr_in == csf_pkg::ADDR_TXDATA |-> wb_dat_out == 32'h0)
    else $error("tx data read not zero");
  ctrl_upper_a: assert property (
    rd && wb_adr_in == csf_pkg::ADDR_CTRL |-> wb_dat_out[31:12] == 20'h0)
    else $error("control upper bits set");
  // Output may only move a few cycles after a bit clock rise
  out_paced_a: assert property ($changed(serial_data_out) |->
    $past(serial_bit_clock_in, 3) || $past(serial_bit_clock_in, 4) ||
    $past(serial_bit_clock_in, 5))
    else $error("data out moved without bit clock");
  out_quiet_a: assert property (
    !serial_bit_clock_in [*8] |=> $stable(serial_data_out))
    else $error("data out moved while codec idle");

  cover property (rd && wb_adr_in == csf_pkg::ADDR_RXDATA);
  cover property ($rose(serial_data_out));
  cover property ((req && wb_adr_in == csf_pkg::ADDR_TXDATA) [*8]);
endmodule : csf_properties

bind csf_slave csf_properties u_props (
  .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .serial_bit_clock_in(serial_bit_clock_in),
  .serial_data_out(serial_data_out)
);

`default_nettype wire

//--- testbench/csf_codec_model.sv
// Codec model: drives bit clock, frame sync and data into the slave.
// Assumes the bench calls frame() and gets back the device's bits.
`default_nettype none

module csf_codec_model (
  output var csf_pkg::csf_pins_t pins_out,
  input wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins_out = '0;
  // ****************
  // Frame driver
  // ****************
  // Clock stands still between frames, as a real codec's would
  task automatic frame(input int mode, input int n, input logic [63:0] tx,
      input int kick, output logic [63:0] rx);
    rx = '0;
    if (mode == 1)
      pins_out.fsync = !pins_out.fsync;
    else
      pins_out.fsync = 1'b1;
    #83 pins_out.sck = 1'b1;
    #80 pins_out.sck = 1'b0;
    for (int i = 0; i <= n; i++) begin
      if (mode != 1)
        pins_out.fsync = (i == kick);
      pins_out.sdi = (i < n) ? tx[n-1-i] : !pins_out.sdi;
      #75;
      if (i > 0)
        rx[n-i] = sdo_in;
      if (i == n)
        break;
      #5 pins_out.sck = 1'b1;
      #80 pins_out.sck = 1'b0;
    end
  endtask : frame
endmodule : csf_codec_model

`default_nettype wire

//--- testbench/csf_slave_tb.sv
// Bench for csf_slave: Wishbone master, codec model, reference model.
// Assumes the checker is bound in and the codec model is compiled.
`default_nettype none

module csf_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic sdo;
  csf_pkg::csf_pins_t pins;
  int n_mismatch = 0;
  int total_checks = 0;
  int tbl[7][6] = '{'{0, 1, 2, 7, 2, -1}, '{1, 1, 1, 15, 1, -1},
    '{1, 1, 2, 3, 2, -1}, '{2, 1, 2, 11, 2, -1}, '{3, 1, 3, 3, 3, 5},
    '{0, 1, 1, 0, 0, -1}, '{0, 0, 1, 7, 1, -1}};

  always #10 clk_in = !clk_in;
  csf_codec_model codec (.pins_out(pins), .sdo_in(sdo));
  csf_slave DUT (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .serial_bit_clock_in(pins.sck), .frame_sync_pin_in(pins.fsync),
    .serial_data_in(pins.sdi), .serial_data_out(sdo));

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic run(input int mode, dir, nw, ws, npush, kick);
    logic [63:0] tx, rx, got;
    logic [31:0] q, w, r, mask, exp_st;
    logic [31:0] txq[$];
    tx = '0;
    rx = '0;
    r = '0;
    mask = (32'h1 << (ws + 1)) - 32'h1;
    bus(1, csf_pkg::ADDR_CTRL,
      {20'h0, 4'(nw - 1), 4'(ws), 2'(mode), 1'(dir), 1'b1}, q);
    for (int k = 0; k < nw; k++) begin
      w = $urandom;
      r = $urandom & mask;
      txq.push_back(w);
      tx = (tx << (ws + 1)) | 64'(k < npush ? w & mask : 32'h0);
      rx = (rx << (ws + 1)) | 64'(r);
    end
    for (int k = 0; k < npush && k < 2; k++)
      bus(1, csf_pkg::ADDR_TXDATA, txq[k], q);
    if (npush >= 2) begin
      bus(0, csf_pkg::ADDR_STATUS, 0, q);
      check(q, 32'h1 << csf_pkg::ST_FULL_BIT);
    end
    fork
      for (int k = 2; k < npush; k++)
        bus(1, csf_pkg::ADDR_TXDATA, txq[k], q);
      codec.frame(mode, nw * (ws + 1), rx, kick, got);
    join
    repeat (8) @(posedge clk_in);
    exp_st = (32'h1 << csf_pkg::ST_RXV_BIT) |
      (32'h1 << csf_pkg::ST_EMPTY_BIT);
    if (nw > 1)
      exp_st |= 32'h1 << csf_pkg::ST_OVR_BIT;
    if (npush < nw)
      exp_st |= 32'h1 << csf_pkg::ST_UNF_BIT;
    bus(0, csf_pkg::ADDR_STATUS, 0, q);
    check(q, dir ? exp_st : 32'h0);
    if (dir) begin
      check(got, tx);
      bus(0, csf_pkg::ADDR_RXDATA, 0, q);
      check(q, r);
    end
    bus(1, csf_pkg::ADDR_STATUS, 32'hc, q);
  endtask : run

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ****************
  // Sequence
  // ****************
  initial begin
    #200us;
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] q;
    void'($urandom(20490));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(0, csf_pkg::ADDR_CTRL, 0, q);
    check(q, csf_pkg::CTRL_RST);
    bus(0, csf_pkg::ADDR_STATUS, 0, q);
    check(q, 32'h1 << csf_pkg::ST_EMPTY_BIT);
    bus(1, 8'h40, 32'hffff_ffff, q);
    bus(0, 8'h40, 0, q);
    check(q, 32'h0);
    bus(0, csf_pkg::ADDR_TXDATA, 0, q);
    check(q, 32'h0);
    bus(0, csf_pkg::ADDR_CTRL, 0, q);
    check(q, csf_pkg::CTRL_RST);
    $display("test reset done");
    foreach (tbl[i]) begin
      run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4],
        tbl[i][5]);
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule : csf_slave_tb

`default_nettype wire
